/* File: pkg/dmaci_map.svh */
// Register offsets, field positions and reset values of the channel block
`ifndef DMACI_MAP_SVH
`define DMACI_MAP_SVH

// Byte offsets of the channel register set
`define DMACI_OFF_PCIE_ICTL 7'h60
`define DMACI_OFF_PCIE_IST 7'h64
`define DMACI_OFF_AXI_ICTL 7'h68
`define DMACI_OFF_AXI_IST 7'h6c
`define DMACI_OFF_PCIE_TRIG 7'h70
`define DMACI_OFF_AXI_TRIG 7'h74
`define DMACI_OFF_CTRL 7'h78
`define DMACI_OFF_STATUS 7'h7c

// Interrupt control fields
`define DMACI_ICTL_MIEN 0
`define DMACI_ICTL_ERR_EN 1
`define DMACI_ICTL_SGL_EN 2
`define DMACI_ICTL_CNT_LSB 16
`define DMACI_ICTL_WMASK 32'h00ff0007

// Interrupt status and trigger fields
`define DMACI_IST_ERR 1
`define DMACI_IST_SGL 2
`define DMACI_IST_SW 3

// Channel control fields
`define DMACI_CTRL_EN 0
`define DMACI_CTRL_FLUSH 1
`define DMACI_CTRL_ELEM64 2
`define DMACI_CTRL_WMASK 32'h00000007

// Channel status fields
`define DMACI_STAT_RUN 0
`define DMACI_STAT_NUM_LSB 4
`define DMACI_STAT_PRESENT 15

// Reset values
`define DMACI_RST_WORD 32'h00000000
`define DMACI_RST_CNT 8'h00

`endif

/* File: pkg/dmaci_pkg.sv */
// Types shared by the channel control and interrupt block
package dmaci_pkg;

    // Bus slave handshake states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } dmaci_bus_state_t;

    // Completion report of one source scatter-gather element
    typedef struct packed {
        logic done;
        logic end_of_packet_flag;
        logic irq_flag;
    } dmaci_elem_done_t;

    // Avalon-MM request bundle from the master
    typedef struct packed {
        logic [6:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } dmaci_avmm_req_t;

endpackage

/* File: logic/dmaci_top.sv */
// Channel control, status and interrupt logic of a scatter-gather DMA channel
`timescale 1ns/1ps
`include "dmaci_map.svh"

module dmaci_top #(
    parameter logic [9:0] CHAN_NUM = 10'h000, // Channel number, strapped
    parameter int QUEUES = 4 // Source, destination and two status queues
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Avalon-MM register slave
    input wire dmaci_pkg::dmaci_avmm_req_t avmm_req_in,
    output logic [31:0] avmm_readdata_out,
    output logic avmm_waitrequest_out,
    // Events from the channel datapath
    input wire dmaci_pkg::dmaci_elem_done_t src_elem_done_in,
    input wire logic dma_error_in,
    input wire logic [QUEUES-1:0] queue_avail_in,
    input wire logic work_busy_in,
    // Control towards the channel datapath
    output logic chan_enable_out,
    output logic fifo_flush_out,
    output logic status_elem64_out,
    output logic xfer_stall_out,
    // Interrupt lines, PCIe side then AXI side
    output logic pcie_irq_out,
    output logic axi_irq_out
);

    // The slave always answers after exactly one wait state. A request
    // seen in the idle state moves to the ack state, where waitrequest
    // is low and the write lands. Software never sees a variable latency,
    // which keeps the bus path short at the cost of one cycle per access.
    // Bus handshake state and registered answers
    dmaci_pkg::dmaci_bus_state_t bus_state_ff;
    dmaci_pkg::dmaci_bus_state_t nxt_bus_state;
    logic [31:0] rdata_ff; // Read data captured as the request is seen
    logic waitreq_ff; // Low for exactly one cycle per access

    // Register storage, index 0 is the PCIe side, 1 the AXI side
    logic [31:0] ictl_ff [2]; // Interrupt control per side
    logic [3:0] ist_ff [2]; // Sticky interrupt status per side
    logic [7:0] coal_cnt_ff [2]; // Coalesce counters per side
    logic irq_ff [2]; // Interrupt lines per side
    logic [31:0] ctrl_ff; // Channel control
    logic running_ff; // Running flag seen by software
    logic stall_ff; // Transfer stall towards the datapath

    // Writes only take effect in the ack cycle, so a request that is
    // dropped early by the master never changes a register. Reads are
    // captured in the idle cycle so the data can come from a flop.
    // Decoded access strobes
    wire req_any = avmm_req_in.read | avmm_req_in.write;
    wire wr_acc = avmm_req_in.write & (bus_state_ff == dmaci_pkg::BUS_ACK);
    wire rd_start = req_any & (bus_state_ff == dmaci_pkg::BUS_IDLE);
    wire [6:0] addr_w = {avmm_req_in.address[6:2], 2'b00};
    wire [31:0] be_mask = {{8{avmm_req_in.byteenable[3]}},
                           {8{avmm_req_in.byteenable[2]}},
                           {8{avmm_req_in.byteenable[1]}},
                           {8{avmm_req_in.byteenable[0]}}};
    wire [31:0] wbits = avmm_req_in.writedata & be_mask; // Enabled ones

    // Per-side address decode
    wire [1:0] sel_ictl = {addr_w == `DMACI_OFF_AXI_ICTL,
                           addr_w == `DMACI_OFF_PCIE_ICTL};
    wire [1:0] sel_ist = {addr_w == `DMACI_OFF_AXI_IST,
                          addr_w == `DMACI_OFF_PCIE_IST};
    wire [1:0] sel_trig = {addr_w == `DMACI_OFF_AXI_TRIG,
                           addr_w == `DMACI_OFF_PCIE_TRIG};
    wire sel_ctrl = addr_w == `DMACI_OFF_CTRL;
    wire sel_stat = addr_w == `DMACI_OFF_STATUS;

    // Channel control fields
    wire chan_en = ctrl_ff[`DMACI_CTRL_EN];

    // Only a flagged last element of a packet counts as an SCATTER_GATHER_LIST event
    wire sgl_evt = src_elem_done_in.done
                   & src_elem_done_in.end_of_packet_flag
                   & src_elem_done_in.irq_flag;

    // Status word as software sees it
    wire [31:0] stat_word = {16'h0000, 1'b1, 1'b0, CHAN_NUM, 3'h0,
                             running_ff};

    // Trigger words are write only; reading them must have no effect,
    // so they simply fall through to the zero default below.
    // Read data selection; unmapped or write-only words read as zero
    wire [31:0] rd_mux =
        sel_ictl[0] ? ictl_ff[0] :
        sel_ist[0] ? {28'h0000000, ist_ff[0]} :
        sel_ictl[1] ? ictl_ff[1] :
        sel_ist[1] ? {28'h0000000, ist_ff[1]} :
        sel_ctrl ? ctrl_ff :
        sel_stat ? stat_word :
        32'h00000000;

    // Next bus state: idle sees a request, the ack cycle always returns
    always_comb begin
        case (bus_state_ff)
            dmaci_pkg::BUS_IDLE: begin
                nxt_bus_state = req_any ? dmaci_pkg::BUS_ACK
                                        : dmaci_pkg::BUS_IDLE;
            end
            dmaci_pkg::BUS_ACK: begin
                nxt_bus_state = dmaci_pkg::BUS_IDLE;
            end
            default: begin
                nxt_bus_state = dmaci_pkg::BUS_IDLE;
            end
        endcase
    end

    // Bus slave: one wait state, read data held through the ack cycle
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus_state_ff <= dmaci_pkg::BUS_IDLE;
            waitreq_ff <= 1'b1;
            rdata_ff <= `DMACI_RST_WORD;
        end else begin
            bus_state_ff <= nxt_bus_state;
            waitreq_ff <= nxt_bus_state != dmaci_pkg::BUS_ACK;
            if (rd_start) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    // Reserved control bits are masked on write and always read zero.
    // The flush bit is a level: the datapath flushes for as long as
    // software leaves it set, there is no self-clearing pulse.
    // Channel control register; byte enables merge into the old value
    wire [31:0] nxt_ctrl = (ctrl_ff & ~be_mask)
                           | (wbits & `DMACI_CTRL_WMASK);
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_ff <= `DMACI_RST_WORD;
        end else if (wr_acc && sel_ctrl) begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Both flags are registered, so they lag their causes by one cycle;
    // software polling the running flag never sees that difference.
    // Datapath view of the channel: stall and running flag
    // Running also covers the enabled state, so a freshly disabled
    // channel reads busy until the datapath reports it has drained.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stall_ff <= 1'b0;
            running_ff <= 1'b0;
        end else begin
            stall_ff <= chan_en & ~(&queue_avail_in);
            running_ff <= chan_en | work_busy_in;
        end
    end

    // Both sides share one structure: a control word, a coalesce
    // counter, sticky status and one level interrupt line. Only the
    // register offsets differ, so one loop builds both copies.
    // A status bit stands until software writes one to it, or until
    // the discard condition drops the held SCATTER_GATHER_LIST and error bits. The
    // software bit survives a disabled channel on purpose.
    // Interrupt logic, one copy per side
    genvar s;
    generate
        for (s = 0; s < 2; s++) begin : g_side
            wire mien = ictl_ff[s][`DMACI_ICTL_MIEN];
            wire [7:0] coal_lim = ictl_ff[s][`DMACI_ICTL_CNT_LSB +: 8];
            // Disabled SCATTER_GATHER_LIST interrupts do not advance the counter either
            wire sgl_use = sgl_evt & ictl_ff[s][`DMACI_ICTL_SGL_EN];
            wire coal_hit = sgl_use & (coal_cnt_ff[s] == coal_lim);
            wire err_set = dma_error_in & ictl_ff[s][`DMACI_ICTL_ERR_EN];
            wire sw_set = wr_acc & sel_trig[s]
                          & wbits[`DMACI_IST_SW];
            wire [3:0] set_v = {sw_set, coal_hit, err_set, 1'b0};
            // Write one to clear; held events dropped when disabled
            wire [3:0] clr_w = (wr_acc & sel_ist[s]) ? wbits[3:0] : 4'h0;
            wire [3:0] clr_d = (!chan_en && !mien) ? 4'h6 : 4'h0;
            wire [3:0] nxt_ist = (ist_ff[s] & ~(clr_w | clr_d)) | set_v;
            wire [31:0] nxt_ictl = (ictl_ff[s] & ~be_mask)
                                   | (wbits & `DMACI_ICTL_WMASK);

            // Control word of this side
            always_ff @(posedge mclk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    ictl_ff[s] <= `DMACI_RST_WORD;
                end else if (wr_acc && sel_ictl[s]) begin
                    ictl_ff[s] <= nxt_ictl;
                end
            end

            // Coalesce counter: wraps at the hit, cleared when disabled
            always_ff @(posedge mclk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    coal_cnt_ff[s] <= `DMACI_RST_CNT;
                end else if (!chan_en) begin
                    coal_cnt_ff[s] <= `DMACI_RST_CNT;
                end else if (coal_hit) begin
                    coal_cnt_ff[s] <= `DMACI_RST_CNT;
                end else if (sgl_use) begin
                    coal_cnt_ff[s] <= coal_cnt_ff[s] + 8'h01;
                end
            end

            // An event that arrives in the very cycle of a clear must
            // not be lost, otherwise an interrupt could vanish between
            // the read of the status and its clear by software.
            // Sticky status, set beats clear in the same cycle
            always_ff @(posedge mclk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    ist_ff[s] <= 4'h0;
                end else begin
                    ist_ff[s] <= nxt_ist;
                end
            end

            // Line follows status while master enable is on, else stays low
            always_ff @(posedge mclk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    irq_ff[s] <= 1'b0;
                end else begin
                    irq_ff[s] <= mien & (|ist_ff[s]);
                end
            end
        end
    endgenerate

    // Every output below is a plain wire from a flop, so downstream
    // logic sees no decode glitches and timing stays predictable.
    // Outputs straight from flops
    assign avmm_readdata_out = rdata_ff;
    assign avmm_waitrequest_out = waitreq_ff;
    assign chan_enable_out = ctrl_ff[`DMACI_CTRL_EN];
    assign fifo_flush_out = ctrl_ff[`DMACI_CTRL_FLUSH];
    assign status_elem64_out = ctrl_ff[`DMACI_CTRL_ELEM64];
    assign xfer_stall_out = stall_ff;
    assign pcie_irq_out = irq_ff[0];
    assign axi_irq_out = irq_ff[1];

    // All checks run on the one clock and are silenced during reset,
    // so the reset values are never compared against stale history.
    // Checks on the interrupt and control behaviour
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    pcie_err_gate_a: assert property ($rose(ist_ff[0][1]) |->
        $past(dma_error_in && ictl_ff[0][1]))
        else $error("PCIe error status set without enabled event");
    pcie_sgl_gate_a: assert property ($rose(ist_ff[0][2]) |->
        $past(sgl_evt && ictl_ff[0][2]))
        else $error("PCIe SCATTER_GATHER_LIST status set without enabled event");
    pcie_irq_hold_a: assert property ((ist_ff[0] != 4'h0)
        && !ictl_ff[0][0] |=> !pcie_irq_out)
        else $error("PCIe interrupt not held with master off");
    pcie_irq_fire_a: assert property ((ist_ff[0] != 4'h0)
        && ictl_ff[0][0] |=> pcie_irq_out)
        else $error("PCIe interrupt not asserted with master on");
    held_discard_a: assert property (!chan_en && !ictl_ff[0][0]
        && !dma_error_in && !sgl_evt |=> ist_ff[0][2:1] == 2'b00)
        else $error("Held PCIe interrupts kept while disabled");
    axi_coal_hit_a: assert property (chan_en && g_side[1].coal_hit
        |=> coal_cnt_ff[1] == 8'h00 && ist_ff[1][2] ##1 axi_irq_out
        || !ictl_ff[1][0] || !$past(ictl_ff[1][0]))
        else $error("AXI coalesce hit did not fire and clear");
    axi_coal_clr_a: assert property (!chan_en |=>
        coal_cnt_ff[1] == 8'h00)
        else $error("AXI coalesce counter kept while disabled");
    coal_cause_a: assert property (coal_cnt_ff[0] != 8'h00 &&
        coal_cnt_ff[0] != $past(coal_cnt_ff[0]) |->
        $past(src_elem_done_in.end_of_packet_flag
              && src_elem_done_in.irq_flag))
        else $error("Coalesce counter moved without flagged element");
    axi_irq_hold_a: assert property (!ictl_ff[1][0] |=>
        !axi_irq_out)
        else $error("AXI interrupt asserted with master off");
    pcie_sw_trig_a: assert property (wr_acc && sel_trig[0]
        && wbits[3] |=> ist_ff[0][3])
        else $error("PCIe software trigger lost");
    axi_sw_trig_a: assert property (wr_acc && sel_trig[1]
        && wbits[3] |=> ist_ff[1][3])
        else $error("AXI software trigger lost");
    flush_write_a: assert property (wr_acc && sel_ctrl
        && avmm_req_in.byteenable[0]
        |=> fifo_flush_out == $past(avmm_req_in.writedata[1]))
        else $error("Flush bit did not follow write");
    stall_queue_a: assert property (chan_en && !(&queue_avail_in)
        |=> xfer_stall_out)
        else $error("No stall while a queue is empty");
    present_read_a: assert property (rd_start && sel_stat
        |=> avmm_readdata_out[15] && !avmm_waitrequest_out)
        else $error("Present bit not read as one");
    running_busy_a: assert property (work_busy_in |=>
        running_ff)
        else $error("Running flag low while work outstanding");

    // Other-side gate, coalescing and interrupt checks, then control, status and bus checks
    axi_err_gate_a: assert property ($rose(ist_ff[1][1]) |->
        $past(dma_error_in && ictl_ff[1][1]))
        else $error("AXI error status set without enabled event");
    axi_sgl_gate_a: assert property ($rose(ist_ff[1][2]) |->
        $past(sgl_evt && ictl_ff[1][2]))
        else $error("AXI SCATTER_GATHER_LIST status set without enabled event");
    pcie_hit_a: assert property (chan_en && g_side[0].coal_hit
        |=> coal_cnt_ff[0] == 8'h00 && ist_ff[0][2])
        else $error("PCIe coalesce hit did not fire and clear");
    pcie_coal_clr_a: assert property (!chan_en |=>
        coal_cnt_ff[0] == 8'h00)
        else $error("PCIe coalesce counter kept while disabled");
    axi_coal_step_a: assert property (chan_en && g_side[1].sgl_use
        && !g_side[1].coal_hit
        |=> coal_cnt_ff[1] == $past(coal_cnt_ff[1]) + 8'h01)
        else $error("AXI coalesce counter did not advance");
    pcie_sw_sticky_a: assert property (ist_ff[0][3] && !(wr_acc
        && sel_ist[0] && wbits[3]) |=> ist_ff[0][3])
        else $error("PCIe software status lost without clear");
    axi_irq_fire_a: assert property ((ist_ff[1] != 4'h0)
        && ictl_ff[1][0] |=> axi_irq_out)
        else $error("AXI interrupt not asserted with master on");
    elem_size_a: assert property (wr_acc && sel_ctrl
        && avmm_req_in.byteenable[0]
        |=> status_elem64_out == $past(avmm_req_in.writedata[2]))
        else $error("Element size bit did not follow write");
    chan_enable_a: assert property (wr_acc && sel_ctrl
        && avmm_req_in.byteenable[0]
        |=> chan_enable_out == $past(avmm_req_in.writedata[0]))
        else $error("Enable bit did not follow write");
    stall_idle_a: assert property (!chan_en |=> !xfer_stall_out)
        else $error("Stall raised while channel disabled");
    chan_num_a: assert property (rd_start && sel_stat
        |=> avmm_readdata_out[13:4] == CHAN_NUM)
        else $error("Channel number not read back");
    idle_running_a: assert property (!chan_en && !work_busy_in
        |=> !running_ff)
        else $error("Running flag high with no work");
    one_wait_a: assert property (!avmm_waitrequest_out |=>
        avmm_waitrequest_out)
        else $error("Waitrequest low for more than one cycle");

    // Main scenarios that the bench is expected to reach

    sgl_pcie_c: cover property (pcie_irq_out && ist_ff[0][2]);
    axi_coal_c: cover property (g_side[1].coal_hit && coal_cnt_ff[1] != 0);
    held_rel_c: cover property (!ictl_ff[0][0] && ist_ff[0] != 4'h0
        ##1 ictl_ff[0][0] ##1 pcie_irq_out);
    sw_trig_c: cover property (wr_acc && sel_trig[1] && !chan_en);
    flush_c: cover property (wr_acc && sel_ctrl && wbits[1]);

endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the channel control and interrupt block
`timescale 1ns/1ps
`include "dmaci_map.svh"

module tb_top;
    localparam logic [9:0] CHAN = 10'h2a5; // Strapped number under test
    localparam int LIMIT = 20000; // Run needs about 330 cycles
    // Design inputs, all given a value at time zero
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    dmaci_pkg::dmaci_avmm_req_t req = '0;
    dmaci_pkg::dmaci_elem_done_t elem = '0;
    logic dma_err = 1'b0;
    logic [3:0] q_avail = 4'hf;
    logic busy = 1'b0;
    // Design outputs
    logic [31:0] rdata;
    logic wreq, en_o, flush_o, e64_o, stall_o, pirq, airq;
    // Bench state
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 33744;
    logic [31:0] got, d;
    logic [7:0] cnt;

    dmaci_top #(.CHAN_NUM(CHAN), .QUEUES(4)) u_dut (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .avmm_req_in(req), .avmm_readdata_out(rdata),
        .avmm_waitrequest_out(wreq), .src_elem_done_in(elem),
        .dma_error_in(dma_err), .queue_avail_in(q_avail),
        .work_busy_in(busy), .chan_enable_out(en_o),
        .fifo_flush_out(flush_o), .status_elem64_out(e64_o),
        .xfer_stall_out(stall_o), .pcie_irq_out(pirq), .axi_irq_out(airq)
    );

    // Free running clock, reset released after two edges
    initial forever #12.5 mclk_in = ~mclk_in;
    initial begin
        repeat (2) @(posedge mclk_in);
        rst_n_in <= 1'b1;
    end

    // Hang guard: a stuck run counts as a mismatch
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e,
                            input logic [31:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask

    // One register access; the request stands until a rising edge that
    // samples waitrequest low, and read data are taken at that edge
    task automatic bus(input logic wr, input logic [6:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge mclk_in);
        req <= '{a, ~wr, wr, wd, 4'hf};
        @(posedge mclk_in);
        while (wreq !== 1'b0) begin
            @(posedge mclk_in);
        end
        rd = rdata;
        req <= '0;
    endtask

    task automatic wr(input logic [6:0] a, input logic [31:0] v);
        bus(1'b1, a, v, got);
    endtask

    task automatic rdc(input string nm, input logic [6:0] a,
                       input logic [31:0] e);
        bus(1'b0, a, 32'h0, got);
        chk_word(nm, e, got);
    endtask

    // One cycle of element completion and error pulses
    task automatic ev(input logic [2:0] e, input logic err);
        @(posedge mclk_in);
        elem <= e;
        dma_err <= err;
        @(posedge mclk_in);
        elem <= '0;
        dma_err <= 1'b0;
    endtask

    // Lets status and line updates land before looking
    task automatic settle();
        repeat (3) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask

    function automatic logic [31:0] exp_stat(input logic run);
        exp_stat = 32'h00008000 | ({22'h0, CHAN} << 4) | {31'h0, run};
    endfunction

    // Side 0 is PCIe, side 1 is AXI
    function automatic logic [6:0] ictl(input int s);
        ictl = s ? `DMACI_OFF_AXI_ICTL : `DMACI_OFF_PCIE_ICTL;
    endfunction

    function automatic logic [6:0] ist(input int s);
        ist = s ? `DMACI_OFF_AXI_IST : `DMACI_OFF_PCIE_IST;
    endfunction

    function automatic logic irq_of(input int s);
        irq_of = s ? airq : pirq;
    endfunction

    initial begin
        @(posedge rst_n_in);
        rdc("status", `DMACI_OFF_STATUS, exp_stat(1'b0));
        rdc("control", `DMACI_OFF_CTRL, 32'h0);
        rdc("unmapped", 7'h00, 32'h0);
        rdc("trigger", `DMACI_OFF_PCIE_TRIG, 32'h0);
        // All ones first, then random words
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 32'hffffffff : $random(seed);
            wr(`DMACI_OFF_CTRL, d);
            rdc("control", `DMACI_OFF_CTRL, d & 32'h7);
            settle();
            chk_bit("enable", d[0], en_o);
            chk_bit("flush", d[1], flush_o);
            chk_bit("elem64", d[2], e64_o);
        end
        $display("test control done");
        wr(`DMACI_OFF_CTRL, 32'h1);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk_in);
            q_avail <= (i == 0) ? 4'hf : 4'($random(seed));
            settle();
            chk_bit("stall", q_avail != 4'hf, stall_o);
        end
        @(posedge mclk_in);
        q_avail <= 4'hf;
        busy <= 1'b1;
        rdc("running", `DMACI_OFF_STATUS, exp_stat(1'b1));
        wr(`DMACI_OFF_CTRL, 32'h0);
        rdc("draining", `DMACI_OFF_STATUS, exp_stat(1'b1));
        @(posedge mclk_in);
        busy <= 1'b0;
        rdc("idle", `DMACI_OFF_STATUS, exp_stat(1'b0));
        $display("test stall and running done");
        for (int s = 0; s < 2; s++) begin
            wr(`DMACI_OFF_CTRL, 32'h1);
            // Zero count on PCIe, random count on AXI
            cnt = (s == 0) ? 8'h00 : 8'($random(seed) & 3) + 8'h01;
            wr(ictl(s), {8'h00, cnt, 16'h0005});
            for (int k = 0; k <= int'(cnt); k++) begin
                ev(3'b111, 1'b0);
                settle();
                chk_bit("sgl line", k == int'(cnt), irq_of(s));
            end
            rdc("sgl status", ist(s), 32'h4);
            wr(ist(s), 32'h4);
            rdc("sgl cleared", ist(s), 32'h0);
            wr(ictl(s), 32'h5);
            ev(3'b110, 1'b0);
            ev(3'b101, 1'b0);
            settle();
            rdc("flags alone", ist(s), 32'h0);
            ev(3'b000, 1'b1);
            settle();
            rdc("error masked", ist(s), 32'h0);
            // Error enabled but master enable off: held, not driven
            wr(ictl(s), 32'h2);
            ev(3'b000, 1'b1);
            settle();
            rdc("error held", ist(s), 32'h2);
            chk_bit("held line", 1'b0, irq_of(s));
            wr(ictl(s), 32'h3);
            settle();
            chk_bit("released line", 1'b1, irq_of(s));
            wr(ictl(s), 32'h2);
            wr(`DMACI_OFF_CTRL, 32'h0);
            settle();
            rdc("discarded", ist(s), 32'h0);
            // Counter halfway, channel off and on, counting restarts
            wr(`DMACI_OFF_CTRL, 32'h1);
            wr(ictl(s), 32'h00010005);
            ev(3'b111, 1'b0);
            wr(`DMACI_OFF_CTRL, 32'h0);
            wr(`DMACI_OFF_CTRL, 32'h1);
            ev(3'b111, 1'b0);
            settle();
            chk_bit("count restarted", 1'b0, irq_of(s));
            ev(3'b111, 1'b0);
            settle();
            chk_bit("count fired", 1'b1, irq_of(s));
            wr(ist(s), 32'hf);
            // Software interrupt while the channel is off
            wr(`DMACI_OFF_CTRL, 32'h0);
            wr(ictl(s), 32'h1);
            wr(s ? `DMACI_OFF_AXI_TRIG : `DMACI_OFF_PCIE_TRIG, 32'h8);
            settle();
            rdc("software", ist(s), 32'h8);
            chk_bit("software line", 1'b1, irq_of(s));
            wr(ist(s), 32'h8);
            settle();
            chk_bit("line cleared", 1'b0, irq_of(s));
            $display("test interrupt side %0d done", s);
        end
        tally_and_finish();
    end
endmodule
